// ===== ccio_consts.svh
/*
  Constants for the counter control input/output select block: register
  offsets, field positions, reset values and timing counts.
  Assumes a 25 MHz clock and an Avalon-MM slave with 32-bit word addressing.
*/
// Behaviour
// - Each control input selects one of four functions
// - Three shared sampling start, stop, clock inputs
// - Sample on external clock falling edge only
// - Software picks rise or fall edge per input, except the sample clock
// - Each control output selects one of four sources
// - General output is level, events give one-shot
// - Software selects output polarity per channel
`ifndef CCIO_CONSTS_SVH
`define CCIO_CONSTS_SVH

`define CCIO_CLK_MHZ         25
`define CCIO_MIN_PULSE_NS    50
`define CCIO_MIN_PULSE_CYC   (((`CCIO_MIN_PULSE_NS * `CCIO_CLK_MHZ) + 999) / 1000)

// Word offsets (byte address = 4 * offset)
`define CCIO_REG_IN_FUNC     4'h0
`define CCIO_REG_IN_EDGE     4'h1
`define CCIO_REG_OUT_SRC     4'h2
`define CCIO_REG_OUT_POL     4'h3
`define CCIO_REG_GP_OUT      4'h4
`define CCIO_REG_PULSE_LEN   4'h5
`define CCIO_REG_PIN_STATE   4'h6
`define CCIO_REG_IRQ_STATUS  4'h7
`define CCIO_REG_IRQ_MASK    4'h8

// Edge register field positions
`define CCIO_EDGE_START_BIT  4
`define CCIO_EDGE_STOP_BIT   5

// Reset values and unmapped read data
`define CCIO_PULSE_LEN_RST   16'h00FA
`define CCIO_UNMAPPED_DATA   32'h00000000

`endif

// ===== ccio_far.sv
/*
  Far-side model: control and sampling pins, pulled up while idle.
  Assumes the bench calls drive from its main thread, just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ccio_far (
  input  wire logic       clk,
  output logic      [3:0] chan_ctrl_in,
  output logic            sample_clock_pin,
  output logic            sample_start_pin,
  output logic            sample_stop_pin
);
  logic [6:0] pins = 7'h7F;
  assign {sample_stop_pin, sample_start_pin, sample_clock_pin, chan_ctrl_in} = pins;
  // Each level held three clocks, above the minimum pulse width
  task automatic drive(input int p, input logic v);
    pins[p] <= v;
    repeat (3) @(posedge clk);
  endtask : drive
endmodule : ccio_far
`default_nettype wire

// ===== ccio_pkg.sv
/*
  Types for the counter control input/output select block.
  Assumes nothing beyond the constants header.
*/
`default_nettype none
package ccio_pkg;
  typedef enum logic [1:0] {
    CCIO_IN_GENERAL,
    CCIO_IN_STARTSTOP,
    CCIO_IN_PRESET,
    CCIO_IN_ZERO
  } ccio_in_func_t;

  typedef enum logic [1:0] {
    CCIO_OUT_GENERAL,
    CCIO_OUT_MATCH,
    CCIO_OUT_ABNORMAL,
    CCIO_OUT_FILTER
  } ccio_out_src_t;
endpackage : ccio_pkg
`default_nettype wire

// ===== ccio_top.sv
/*
  Control input edge logic and control output select for four counter
  channels, plus the shared sampling start, stop and clock inputs.
  Assumes pins are asynchronous to clk and the counter core consumes the
  one-cycle pulses and supplies the one-cycle event strobes.
*/
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ccio_consts.svh"
`default_nettype none
module ccio_top
  import ccio_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [3:0]  chan_ctrl_in,
  input  wire logic        sample_clock_pin,
  input  wire logic        sample_start_pin,
  input  wire logic        sample_stop_pin,
  input  wire logic [3:0]  match_event,
  input  wire logic [3:0]  abnormal_event,
  input  wire logic [3:0]  filter_event,
  output logic      [3:0]  chan_ctrl_out,
  output logic      [3:0]  count_startstop,
  output logic      [3:0]  count_preset,
  output logic      [3:0]  count_zero,
  output logic      [3:0]  gp_in_level,
  output logic             ext_sample_clock_in,
  output logic             ext_sample_start_in,
  output logic             ext_sample_stop_in,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rst_sync;
  wire        rst_n = rst_sync[1];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rst_sync <= 2'h0;
    else       rst_sync <= {rst_sync[0], 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  in_func;
  logic [5:0]  in_edge;
  logic [7:0]  out_src;
  logic [3:0]  out_pol;
  logic [3:0]  gp_out;
  logic [15:0] pulse_len;
  logic [6:0]  irq_status;
  logic [6:0]  irq_mask;

  wire wr = avs_write && !avs_waitrequest;
  wire rd = avs_read && !avs_waitrequest;
  wire wr_func  = wr && (avs_address == `CCIO_REG_IN_FUNC);
  wire wr_edge  = wr && (avs_address == `CCIO_REG_IN_EDGE);
  wire wr_src   = wr && (avs_address == `CCIO_REG_OUT_SRC);
  wire wr_pol   = wr && (avs_address == `CCIO_REG_OUT_POL);
  wire wr_gp    = wr && (avs_address == `CCIO_REG_GP_OUT);
  wire wr_len   = wr && (avs_address == `CCIO_REG_PULSE_LEN);
  wire wr_stat  = wr && (avs_address == `CCIO_REG_IRQ_STATUS);
  wire wr_mask  = wr && (avs_address == `CCIO_REG_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: three stages, change accepted when stages 2 and 3 agree
  localparam int NIN = 7;
  wire  [NIN-1:0] pins = {sample_stop_pin, sample_start_pin, sample_clock_pin, chan_ctrl_in};
  logic [NIN-1:0] s1, s2, s3, lvl;

  // Pins idle high on their pull-ups; start there so reset makes no edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1  <= '1;
      s2  <= '1;
      s3  <= '1;
      lvl <= '1;
    end else begin
      s1  <= pins;
      s2  <= s1;
      s3  <= s2;
      lvl <= (s2 & s3) | (lvl & ~(~s2 & ~s3));
    end
  end

  wire [NIN-1:0] next_lvl = (s2 == s3) ? s2 : lvl;
  wire [NIN-1:0] rise     = next_lvl & ~lvl;
  wire [NIN-1:0] fall     = ~next_lvl & lvl;

  // Edge choice per input except the sample clock (falling only): bit set selects falling edge
  wire [3:0] chan_edge  = (rise[3:0] & ~in_edge[3:0]) | (fall[3:0] & in_edge[3:0]);
  wire       start_edge = in_edge[`CCIO_EDGE_START_BIT] ? fall[5] : rise[5];
  wire       stop_edge  = in_edge[`CCIO_EDGE_STOP_BIT] ? fall[6] : rise[6];
  wire       clk_edge   = fall[4];

  logic [3:0] next_ss, next_pre, next_zero;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_ss[i]   = chan_edge[i] && (ccio_in_func_t'(in_func[2*i +: 2]) == CCIO_IN_STARTSTOP);
      next_pre[i]  = chan_edge[i] && (ccio_in_func_t'(in_func[2*i +: 2]) == CCIO_IN_PRESET);
      next_zero[i] = chan_edge[i] && (ccio_in_func_t'(in_func[2*i +: 2]) == CCIO_IN_ZERO);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_startstop     <= 4'h0;
      count_preset        <= 4'h0;
      count_zero          <= 4'h0;
      gp_in_level         <= 4'h0;
      ext_sample_clock_in <= 1'b0;
      ext_sample_start_in <= 1'b0;
      ext_sample_stop_in  <= 1'b0;
    end else begin
      count_startstop     <= next_ss;
      count_preset        <= next_pre;
      count_zero          <= next_zero;
      gp_in_level         <= lvl[3:0];
      ext_sample_clock_in <= clk_edge;
      ext_sample_start_in <= start_edge;
      ext_sample_stop_in  <= stop_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs: level or one-shot, with polarity
  logic [3:0]  shot;
  logic [15:0] shot_cnt [4];
  logic [3:0]  ev;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      unique case (ccio_out_src_t'(out_src[2*i +: 2]))
        CCIO_OUT_GENERAL:  ev[i] = 1'b0;
        CCIO_OUT_MATCH:    ev[i] = match_event[i];
        CCIO_OUT_ABNORMAL: ev[i] = abnormal_event[i];
        CCIO_OUT_FILTER:   ev[i] = filter_event[i];
      endcase
    end
  end

  wire [3:0] is_gp;
  for (genvar g = 0; g < 4; g++) begin : g_out
    assign is_gp[g] = (ccio_out_src_t'(out_src[2*g +: 2]) == CCIO_OUT_GENERAL);

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        shot[g]     <= 1'b0;
        shot_cnt[g] <= 16'h0000;
      end else if (ev[g]) begin
        shot[g]     <= 1'b1;
        shot_cnt[g] <= pulse_len;
      end else if (shot_cnt[g] > 16'h0001) begin
        shot_cnt[g] <= shot_cnt[g] - 16'h0001;
      end else begin
        shot[g]     <= 1'b0;
        shot_cnt[g] <= 16'h0000;
      end
    end
  end

  wire [3:0] active = (is_gp & gp_out) | (~is_gp & shot);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: four channel-input events and three sampling events
  wire [6:0] irq_ev = {stop_edge, start_edge, clk_edge, chan_edge};
  wire [6:0] next_status = (irq_status & ~({7{wr_stat}} & avs_writedata[6:0])) | irq_ev;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  wire [31:0] rd_mux =
    (avs_address == `CCIO_REG_IN_FUNC)   ? {24'h0, in_func} :
    (avs_address == `CCIO_REG_IN_EDGE)   ? {26'h0, in_edge} :
    (avs_address == `CCIO_REG_OUT_SRC)   ? {24'h0, out_src} :
    (avs_address == `CCIO_REG_OUT_POL)   ? {28'h0, out_pol} :
    (avs_address == `CCIO_REG_GP_OUT)    ? {28'h0, gp_out} :
    (avs_address == `CCIO_REG_PULSE_LEN) ? {16'h0, pulse_len} :
    (avs_address == `CCIO_REG_PIN_STATE) ? {21'h0, lvl, chan_ctrl_out} :
    (avs_address == `CCIO_REG_IRQ_STATUS)? {25'h0, irq_status} :
    (avs_address == `CCIO_REG_IRQ_MASK)  ? {25'h0, irq_mask} :
    `CCIO_UNMAPPED_DATA;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_func    <= 8'h00;
      in_edge    <= 6'h00;
      out_src    <= 8'h00;
      out_pol    <= 4'h0;
      gp_out     <= 4'h0;
      pulse_len  <= `CCIO_PULSE_LEN_RST;
      irq_status <= 7'h00;
      irq_mask   <= 7'h00;
    end else begin
      if (wr_func) in_func   <= avs_writedata[7:0];
      if (wr_edge) in_edge   <= avs_writedata[5:0];
      if (wr_src)  out_src   <= avs_writedata[7:0];
      if (wr_pol)  out_pol   <= avs_writedata[3:0];
      if (wr_gp)   gp_out    <= avs_writedata[3:0];
      if (wr_len)  pulse_len <= avs_writedata[15:0];
      if (wr_mask) irq_mask  <= avs_writedata[6:0];
      irq_status <= next_status;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_ctrl_out <= 4'h0;
      irq           <= 1'b0;
    end else begin
      chan_ctrl_out <= active ^ out_pol;
      irq           <= |(next_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_clock_falls_only: assert property (@(posedge clk) disable iff (!rst_n)
    ext_sample_clock_in |-> $past(lvl[4]) && !lvl[4])
    else $error("sample clock pulse without falling edge");

  a_start_edge_sel: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(lvl[5]) && !in_edge[`CCIO_EDGE_START_BIT] && !$past(wr_edge)) |-> ext_sample_start_in)
    else $error("start rise missed");

  a_func_preset: assert property (@(posedge clk) disable iff (!rst_n)
    count_preset[0] |-> $past(in_func[1:0]) == 2'h2)
    else $error("preset pulse under wrong function");

  a_func_exclusive: assert property (@(posedge clk) disable iff (!rst_n)
    !(count_preset[0] && count_zero[0]))
    else $error("preset and zero together");

  a_pulse_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    count_zero[1] |=> !count_zero[1])
    else $error("zero pulse longer than a cycle");

  a_gp_level: assert property (@(posedge clk) disable iff (!rst_n)
    (is_gp[0] && $stable(gp_out[0]) && $stable(out_pol[0]) && $stable(is_gp[0]))
      |-> chan_ctrl_out[0] == (gp_out[0] ^ out_pol[0]))
    else $error("general output not level");

  a_shot_starts: assert property (@(posedge clk) disable iff (!rst_n)
    (ev[2] && pulse_len > 16'h0002) |=> ##1 shot[2])
    else $error("one-shot did not start");

  a_out_polarity: assert property (@(posedge clk) disable iff (!rst_n)
    chan_ctrl_out[3] == ($past(active[3]) ^ $past(out_pol[3])))
    else $error("output polarity wrong");

  a_src_match: assert property (@(posedge clk) disable iff (!rst_n)
    (out_src[3:2] == 2'h1 && match_event[1]) |=> shot[1])
    else $error("match event not routed");

endmodule : ccio_top
`default_nettype wire

// ===== ccio_top_tb.sv
/*
  Self-checking bench: pin edges to pulses, output select, registers, interrupt.
  Assumes the design answers each bus request with one low waitrequest cycle.
*/
`timescale 1ns/1ps
`include "ccio_consts.svh"
`default_nettype none
module ccio_top_tb;
  import ccio_pkg::*;
  typedef struct {
    logic [31:0] func;
    logic [31:0] edg;
    int          pin;
    logic [14:0] ef;
    logic [14:0] er;
  } ccio_row_t;
  ccio_row_t rows [11] = '{
    '{32'h2, 32'h1, 0, 15'h0010, 15'h0000}, '{32'hC, 32'h0, 1, 15'h0000, 15'h0200},
    '{32'h0, 32'h0, 5, 15'h0000, 15'h2000}, '{32'h0, 32'h20, 6, 15'h4000, 15'h0000},
    '{32'h1, 32'h0, 0, 15'h0000, 15'h0001}, '{32'h8, 32'h2, 1, 15'h0020, 15'h0000},
    '{32'h30, 32'h0, 2, 15'h0000, 15'h0400}, '{32'h0, 32'h0, 3, 15'h0000, 15'h0000},
    '{32'h0, 32'h0, 4, 15'h1000, 15'h0000}, '{32'h0, 32'h10, 5, 15'h2000, 15'h0000},
    '{32'h0, 32'h0, 6, 15'h0000, 15'h4000}};
  logic        clk = 1'b0;
  logic        nrst, avs_read, avs_write, avs_waitrequest, irq;
  logic [3:0]  avs_address, chan_ctrl_in, chan_ctrl_out, count_startstop, count_preset, count_zero, gp_in_level;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        sample_clock_pin, sample_start_pin, sample_stop_pin;
  logic        ext_sample_clock_in, ext_sample_start_in, ext_sample_stop_in;
  logic [3:0]  ev [3];
  int          bad_count = 0, n_checks = 0, cyc = 0, hi = 0;
  always #20 clk = ~clk;
  ccio_top i_ccio_top (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .chan_ctrl_in(chan_ctrl_in), .sample_clock_pin(sample_clock_pin),
    .sample_start_pin(sample_start_pin), .sample_stop_pin(sample_stop_pin), .match_event(ev[0]),
    .abnormal_event(ev[1]), .filter_event(ev[2]), .chan_ctrl_out(chan_ctrl_out),
    .count_startstop(count_startstop), .count_preset(count_preset), .count_zero(count_zero),
    .gp_in_level(gp_in_level), .ext_sample_clock_in(ext_sample_clock_in),
    .ext_sample_start_in(ext_sample_start_in), .ext_sample_stop_in(ext_sample_stop_in), .irq(irq));
  ccio_far i_ccio_far (.clk(clk), .chan_ctrl_in(chan_ctrl_in), .sample_clock_pin(sample_clock_pin),
    .sample_start_pin(sample_start_pin), .sample_stop_pin(sample_stop_pin));
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      results(1'b1);
    end
  end
  // A run that times out counts one extra mismatch
  task automatic results(input logic expired);
    int bad;
    bad = bad_count + int'(expired);
    $display("checks %0d mismatches %0d", n_checks, bad);
    if (bad == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One bus access, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  // One pin level, then the pulses and levels it should give
  task automatic step(input int p, input logic v, input logic [14:0] e);
    logic [3:0]  g;
    logic [14:0] a;
    g = (p < 4 && !v) ? ~(4'h1 << p) : 4'hF;
    a = 15'h0;
    i_ccio_far.drive(p, v);
    repeat (4) begin
      @(negedge clk);
      a = a | {ext_sample_stop_in, ext_sample_start_in, ext_sample_clock_in, count_zero, count_preset,
               count_startstop};
    end
    chk({gp_in_level, a}, {g, e});
  endtask : step
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    ev = '{4'h0, 4'h0, 4'h0};
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({avs_waitrequest, irq, chan_ctrl_out}, 32'h20);
    @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`CCIO_REG_PULSE_LEN, 32'h000000FA);
    wr(4'hF, 32'h5);
    rd(4'hF, 32'h0);
    foreach (rows[i]) begin
      wr(`CCIO_REG_IN_FUNC, rows[i].func);
      wr(`CCIO_REG_IN_EDGE, rows[i].edg);
      repeat (4) @(posedge clk);
      step(rows[i].pin, 1'b0, rows[i].ef);
      @(posedge clk);
      step(rows[i].pin, 1'b1, rows[i].er);
    end
    wr(`CCIO_REG_PULSE_LEN, 32'h5);
    wr(`CCIO_REG_GP_OUT, 32'h1);
    repeat (2) @(negedge clk);
    chk(chan_ctrl_out, 32'h1);
    wr(`CCIO_REG_OUT_POL, 32'hD);
    wr(`CCIO_REG_OUT_SRC, 32'hE4);
    repeat (2) @(negedge clk);
    chk(chan_ctrl_out, 32'hC);
    for (int c = 1; c < 4; c++) begin
      hi = 0;
      for (int k = 0; k < 3; k++) begin
        for (int t = 0; t < 12; t++) begin
          @(posedge clk);
          if (t == 0) ev[k] <= 4'h1 << c;
          if (t == 1) ev[k] <= 4'h0;
          @(negedge clk);
          hi = hi + int'(chan_ctrl_out[c] ^ (c != 1));
        end
      end
      chk(hi, 32'h5);
    end
    wr(`CCIO_REG_IRQ_MASK, 32'h0);
    wr(`CCIO_REG_IRQ_STATUS, 32'h7F);
    rd(`CCIO_REG_IRQ_STATUS, 32'h0);
    @(posedge clk);
    i_ccio_far.drive(0, 1'b0);
    i_ccio_far.drive(0, 1'b1);
    repeat (6) @(posedge clk);
    rd(`CCIO_REG_IRQ_STATUS, 32'h1);
    chk(irq, 32'h0);
    wr(`CCIO_REG_IRQ_MASK, 32'h1);
    repeat (2) @(negedge clk);
    chk(irq, 32'h1);
    wr(`CCIO_REG_IRQ_STATUS, 32'h1);
    repeat (2) @(negedge clk);
    chk(irq, 32'h0);
    // Reset in mid-run: idle-high pins must leave no edge and no status behind
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(negedge clk);
    chk({avs_waitrequest, irq, chan_ctrl_out}, 32'h20);
    @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`CCIO_REG_IRQ_STATUS, 32'h0);
    rd(`CCIO_REG_PIN_STATE, 32'h7F0);
    results(1'b0);
  end
endmodule : ccio_top_tb
`default_nettype wire
